//--- design/external_area_address_decoder.sv
// External area address decoder with APB bus control registers
//
// Functional notes
// R1 - Eight external areas, own kind and width
// R2 - Area chosen from address bits 28..26
// R3 - Address bits 31..29 ignored for area
// R4 - Shadow copies reach the same area
// R5 - Area 0 width from mode pins
// R6 - Other areas width from bus control registers
// R7 - Software: SDRAM only 16/32, areas 2,3
// R8 - Software: area 5B multiplexed I/O is 16
// R9 - Areas 5B, 6A, 6B limited to 8/16
// R10 - Software: ports A/B need 8/16 widths
// R11 - Software never touches reserved area 7
// R12 - Software uses uncached segment for area 1
// R13 - On-chip I/O segment has no shadows
// R14 - Fixed area bases and sizes
// R15 - One active-low select per external area
module external_area_address_decoder #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,               // Bus clock
  input  wire logic              presetn,            // Power-on reset, active low
  input  wire logic              clk_en,             // Clock enable
  input  wire logic              psel,               // APB select
  input  wire logic              penable,            // APB enable
  input  wire logic              pwrite,             // APB write
  input  wire logic [ADDR_W-1:0] paddr,              // APB address
  input  wire logic [31:0]       pwdata,             // APB write data
  output logic      [31:0]       prdata,             // APB read data
  output logic                   pready,             // APB ready
  output logic                   pslverr,            // APB error
  input  wire logic              area0_width_sel_lo, // Area 0 width pin, low
  input  wire logic              area0_width_sel_hi, // Area 0 width pin, high
  input  wire logic              req_valid,          // Access request
  input  wire logic [31:0]       req_addr,           // Access physical address
  output logic                   area0_select_n,     // Area 0 select
  output logic                   area2_select_n,     // Area 2 select
  output logic                   area3_select_n,     // Area 3 select
  output logic                   area4_select_n,     // Area 4 select
  output logic                   area5a_select_n,    // Area 5A select
  output logic                   area5b_select_n,    // Area 5B select
  output logic                   area6a_select_n,    // Area 6A select
  output logic                   area6b_select_n,    // Area 6B select
  output logic                   acc_valid,          // Decoded access valid
  output logic      [1:0]        acc_width,          // Decoded bus width
  output logic      [2:0]        acc_kind,           // Decoded memory kind
  output logic                   acc_internal_io,    // Access to area 1
  output logic                   acc_reserved,       // Access to area 7
  output logic                   acc_onchip_io,      // Access to on-chip I/O
  output logic                   strap_done,         // Area 0 width captured
  output logic                   strap_prohibited    // Pins held code 00
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Per-area settings
    logic [7:0][1:0] width;
    logic [7:0][2:0] kind;
    // Area 0 width capture
    logic [1:0]      strap_cnt;
    logic            strap_done;
    logic            strap_bad;
    // APB response
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    // Decoded access
    logic [7:0]      sel_n;
    logic            acc_valid;
    logic [1:0]      acc_width;
    logic [2:0]      acc_kind;
    logic            acc_internal;
    logic            acc_reserved;
    logic            acc_onchip;
    // Last request, for status
    logic [2:0]      last_code;
    logic            last_res;
    logic            last_onchip;
  } state_t;

  localparam state_t ST_RST = '{
    width:   {8{ead_pkg::RST_WIDTH}},
    kind:    {8{ead_pkg::RST_KIND}},
    sel_n:   8'hFF,
    default: '0
  };

  state_t q;
  state_t d;

  // ----------------------------------------------------------------
  // Legality checks
  // ----------------------------------------------------------------
  // Width legal for this select
  function automatic logic width_ok(
    input logic [2:0] idx,
    input logic [1:0] w
  );
    width_ok = w != ead_pkg::W_BAD;
    if (idx >= ead_pkg::IDX_A5B && w == ead_pkg::W32) begin
      width_ok = 1'b0; // R9
    end
  endfunction

  // Kinds each select may carry
  function automatic logic kind_ok(
    input logic [2:0] idx,
    input logic [2:0] k
  );
    kind_ok = k == ead_pkg::K_NORMAL;
    unique case (idx)
      ead_pkg::IDX_A0:  kind_ok = kind_ok || k == ead_pkg::K_BURST_ROM;
      ead_pkg::IDX_A2,
      ead_pkg::IDX_A3:  kind_ok = kind_ok || k == ead_pkg::K_SDRAM; // R7
      ead_pkg::IDX_A4:  kind_ok = kind_ok || k == ead_pkg::K_BURST_ROM
                                          || k == ead_pkg::K_BYTE_SRAM;
      ead_pkg::IDX_A5B: kind_ok = kind_ok || k == ead_pkg::K_MUX_IO
                                          || k == ead_pkg::K_BYTE_SRAM; // R8
      default:          kind_ok = kind_ok;
    endcase
  endfunction

  // Pairs the far side cannot use
  function automatic logic combo_ok(
    input logic [1:0] w,
    input logic [2:0] k
  );
    combo_ok = 1'b1;
    if (k == ead_pkg::K_SDRAM && w == ead_pkg::W8) begin
      combo_ok = 1'b0; // R7
    end
    if (k == ead_pkg::K_MUX_IO && w != ead_pkg::W16) begin
      combo_ok = 1'b0; // R8
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and address decoder
  // ----------------------------------------------------------------
  logic [1:0] pins_s;

  logic [2:0] dec_code;
  logic [2:0] dec_idx;
  logic       dec_ext;
  logic       dec_internal;
  logic       dec_reserved;
  logic       dec_onchip;

  pin_sync #(
    .W     (2)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (clk_en),
    .d     ({area0_width_sel_hi, area0_width_sel_lo}),
    .q     (pins_s)
  );

  area_decode u_area_decode (
    .addr        (req_addr),
    .area_code   (dec_code),
    .sel_idx     (dec_idx),
    .ext_hit     (dec_ext),
    .internal_io (dec_internal),
    .reserved    (dec_reserved),
    .onchip_io   (dec_onchip)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [2:0]  reg_idx;
  logic        bcr_hit;
  logic        st_hit;
  logic [1:0]  wr_width;
  logic [2:0]  wr_kind;
  logic        wr_ok;
  logic        access;
  logic [31:0] rd_val;

  always_comb begin
    // APB address decode
    reg_idx  = paddr[4:2];
    bcr_hit  = paddr >= ADDR_W'(ead_pkg::OFS_BCR_BASE)
               && paddr <= ADDR_W'(ead_pkg::OFS_BCR_LAST)
               && paddr[1:0] == 2'h0;
    st_hit   = paddr == ADDR_W'(ead_pkg::OFS_STATUS);
    wr_kind  = pwdata[ead_pkg::BCR_KIND_LSB +: 3];
    // Area 0 width belongs to the pins and ignores writes
    wr_width = (reg_idx == ead_pkg::IDX_A0) ? q.width[0]
                                            : pwdata[ead_pkg::BCR_WIDTH_LSB +: 2];
    wr_ok    = kind_ok(reg_idx, wr_kind)
               && combo_ok(wr_width, wr_kind)
               && (reg_idx == ead_pkg::IDX_A0 || width_ok(reg_idx, wr_width));
    access   = psel && penable;

    // Read view of the addressed register
    rd_val   = '0;
    if (bcr_hit) begin
      rd_val[ead_pkg::BCR_WIDTH_LSB +: 2] = q.width[reg_idx];
      rd_val[ead_pkg::BCR_KIND_LSB +: 3]  = q.kind[reg_idx];
    end else if (st_hit) begin
      rd_val[ead_pkg::ST_WIDTH_LSB +: 2] = q.width[0];
      rd_val[ead_pkg::ST_DONE_BIT]       = q.strap_done;
      rd_val[ead_pkg::ST_BAD_BIT]        = q.strap_bad;
      rd_val[ead_pkg::ST_CODE_LSB +: 3]  = q.last_code;
      rd_val[ead_pkg::ST_RES_BIT]        = q.last_res;
      rd_val[ead_pkg::ST_IO_BIT]         = q.last_onchip;
    end

    d         = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;

    // Area 0 width caught once the pins have crossed the synchroniser
    if (!q.strap_done) begin
      if (q.strap_cnt == ead_pkg::STRAP_SETTLE) begin
        d.width[0]   = pins_s; // R5
        d.strap_bad  = pins_s == ead_pkg::W_BAD;
        d.strap_done = 1'b1;
      end else begin
        d.strap_cnt = q.strap_cnt + 2'h1;
      end
    end

    // APB: one wait state, then completion
    if (access && !q.pready) begin
      d.pready  = 1'b1;
      d.prdata  = rd_val;
      d.pslverr = !(bcr_hit || st_hit)
                  || (pwrite && st_hit)
                  || (pwrite && bcr_hit && !wr_ok);
    end
    if (access && q.pready && pwrite && bcr_hit && wr_ok) begin
      d.kind[reg_idx]  = wr_kind; // R1
      d.width[reg_idx] = wr_width; // R6
    end

    // Access decode, registered one cycle after the request
    d.acc_valid    = req_valid;
    d.sel_n        = 8'hFF;
    d.acc_width    = ead_pkg::W_BAD;
    d.acc_kind     = ead_pkg::K_NORMAL;
    d.acc_internal = req_valid && dec_internal;
    d.acc_reserved = req_valid && dec_reserved; // R11
    d.acc_onchip   = req_valid && dec_onchip; // R13
    if (req_valid) begin
      d.last_code   = dec_code;
      d.last_res    = dec_reserved;
      d.last_onchip = dec_onchip;
      if (dec_ext) begin
        d.sel_n     = ~(8'h01 << dec_idx); // R15
        d.acc_width = q.width[dec_idx]; // R1 R6
        d.acc_kind  = q.kind[dec_idx]; // R1
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // APB response
  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;

  // Selects, active low
  assign area0_select_n   = q.sel_n[ead_pkg::IDX_A0];
  assign area2_select_n   = q.sel_n[ead_pkg::IDX_A2];
  assign area3_select_n   = q.sel_n[ead_pkg::IDX_A3];
  assign area4_select_n   = q.sel_n[ead_pkg::IDX_A4];
  assign area5a_select_n  = q.sel_n[ead_pkg::IDX_A5A];
  assign area5b_select_n  = q.sel_n[ead_pkg::IDX_A5B];
  assign area6a_select_n  = q.sel_n[ead_pkg::IDX_A6A];
  assign area6b_select_n  = q.sel_n[ead_pkg::IDX_A6B];

  // Decoded access
  assign acc_valid        = q.acc_valid;
  assign acc_width        = q.acc_width;
  assign acc_kind         = q.acc_kind;
  assign acc_internal_io  = q.acc_internal;
  assign acc_reserved     = q.acc_reserved;
  assign acc_onchip_io    = q.acc_onchip;

  // Area 0 width capture
  assign strap_done       = q.strap_done;
  assign strap_prohibited = q.strap_bad;

endmodule // external_area_address_decoder

//--- design/ead_pkg.sv
// Constants and types shared by the external area address decoder
package ead_pkg;

  // ----------------------------------------------------------------
  // Area layout
  // ----------------------------------------------------------------
  localparam int          NUM_AREAS     = 8;
  localparam int          IDX_W         = 3;
  localparam int          CODE_MSB      = 28;
  localparam int          CODE_LSB      = 26;
  localparam int          SEG_MSB       = 31;
  localparam int          SEG_LSB       = 29;
  localparam int          HALF_BIT      = 25;
  localparam logic [2:0]  SEG_ONCHIP_IO = 3'h7;

  // Area codes seen on address bits 28..26
  localparam logic [2:0]  CODE_A0       = 3'h0;
  localparam logic [2:0]  CODE_A1       = 3'h1;
  localparam logic [2:0]  CODE_A2       = 3'h2;
  localparam logic [2:0]  CODE_A3       = 3'h3;
  localparam logic [2:0]  CODE_A4       = 3'h4;
  localparam logic [2:0]  CODE_A5       = 3'h5;
  localparam logic [2:0]  CODE_A6       = 3'h6;
  localparam logic [2:0]  CODE_A7       = 3'h7;

  // Select index: 0=A0 1=A2 2=A3 3=A4 4=A5A 5=A5B 6=A6A 7=A6B
  localparam logic [2:0]  IDX_A0        = 3'h0;
  localparam logic [2:0]  IDX_A2        = 3'h1;
  localparam logic [2:0]  IDX_A3        = 3'h2;
  localparam logic [2:0]  IDX_A4        = 3'h3;
  localparam logic [2:0]  IDX_A5A       = 3'h4;
  localparam logic [2:0]  IDX_A5B       = 3'h5;
  localparam logic [2:0]  IDX_A6A       = 3'h6;
  localparam logic [2:0]  IDX_A6B       = 3'h7;

  // ----------------------------------------------------------------
  // Widths and memory kinds
  // ----------------------------------------------------------------
  typedef logic [1:0] width_t;
  typedef logic [2:0] kind_t;

  localparam width_t      W_BAD         = 2'h0;
  localparam width_t      W8            = 2'h1;
  localparam width_t      W16           = 2'h2;
  localparam width_t      W32           = 2'h3;

  localparam kind_t       K_NORMAL      = 3'h0;
  localparam kind_t       K_BURST_ROM   = 3'h1;
  localparam kind_t       K_SDRAM       = 3'h2;
  localparam kind_t       K_BYTE_SRAM   = 3'h3;
  localparam kind_t       K_MUX_IO      = 3'h4;

  // ----------------------------------------------------------------
  // Register map (APB byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_BCR_BASE  = 12'h000;
  localparam logic [11:0] OFS_BCR_LAST  = 12'h01C;
  localparam logic [11:0] OFS_STATUS    = 12'h020;
  localparam int          BCR_WIDTH_LSB = 0;
  localparam int          BCR_KIND_LSB  = 2;
  localparam int          ST_WIDTH_LSB  = 0;
  localparam int          ST_DONE_BIT   = 2;
  localparam int          ST_BAD_BIT    = 3;
  localparam int          ST_CODE_LSB   = 4;
  localparam int          ST_RES_BIT    = 7;
  localparam int          ST_IO_BIT     = 8;

  localparam width_t      RST_WIDTH     = W16;
  localparam kind_t       RST_KIND      = K_NORMAL;

  // Cycles the mode pins need to pass the synchroniser after reset
  localparam logic [1:0]  STRAP_SETTLE  = 2'h2;

endpackage

//--- design/pin_sync.sv
// Two flip-flop synchroniser for pin inputs
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,     // Bus clock
  input  wire logic         rst_n,   // Asynchronous reset, active low
  input  wire logic         en,      // Clock enable
  input  wire logic [W-1:0] d,       // Asynchronous input
  output logic      [W-1:0] q        // Synchronised output
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t sq;
  sync_t sd;

  always_comb begin
    sd    = sq;
    sd.s1 = d;
    sd.s2 = sq.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sq <= '0;
    end else if (en) begin
      sq <= sd;
    end
  end

  assign q = sq.s2;

endmodule // pin_sync

//--- design/area_decode.sv
// Physical address to external area decoder
module area_decode (
  input  wire logic [31:0] addr,        // Physical address
  output logic      [2:0]  area_code,   // Area code from bits 28..26
  output logic      [2:0]  sel_idx,     // Index of the external select
  output logic             ext_hit,     // Address hits an external area
  output logic             internal_io, // Area 1 internal registers
  output logic             reserved,    // Area 7 or one of its shadows
  output logic             onchip_io    // On-chip I/O segment
);

  always_comb begin
    area_code   = addr[ead_pkg::CODE_MSB:ead_pkg::CODE_LSB]; // R2 R3 R4
    onchip_io   = addr[ead_pkg::SEG_MSB:ead_pkg::SEG_LSB]
                  == ead_pkg::SEG_ONCHIP_IO; // R13
    internal_io = !onchip_io && area_code == ead_pkg::CODE_A1;
    reserved    = !onchip_io && area_code == ead_pkg::CODE_A7; // R11
    ext_hit     = !onchip_io && !internal_io && !reserved;
    unique case (area_code) // R14
      ead_pkg::CODE_A2: sel_idx = ead_pkg::IDX_A2;
      ead_pkg::CODE_A3: sel_idx = ead_pkg::IDX_A3;
      ead_pkg::CODE_A4: sel_idx = ead_pkg::IDX_A4;
      ead_pkg::CODE_A5: sel_idx = addr[ead_pkg::HALF_BIT] ? ead_pkg::IDX_A5B
                                                          : ead_pkg::IDX_A5A;
      ead_pkg::CODE_A6: sel_idx = addr[ead_pkg::HALF_BIT] ? ead_pkg::IDX_A6B
                                                          : ead_pkg::IDX_A6A;
      default:          sel_idx = ead_pkg::IDX_A0;
    endcase
  end

endmodule // area_decode

//--- dv/ead_mem_model.sv
// Far-side memory bank model: reports which external select is active
module ead_mem_model (
  input  wire logic [7:0] sel_n,   // Selects, active low
  output logic      [3:0] hit_idx, // Active bank, 8 when none
  output logic            multi    // More than one bank selected
);
  timeunit 1ns;
  timeprecision 1ns;

  // Each bank answers only to its own select
  always_comb begin
    hit_idx = 4'h8;
    for (int i = 0; i < 8; i++) begin
      if (!sel_n[i]) begin
        hit_idx = 4'(i);
      end
    end
    multi = ($countones(~sel_n) > 1);
  end
endmodule // ead_mem_model

//--- dv/ead_checker.sv
// Port assertions for the external area address decoder
module ead_checker (
  input wire logic        pclk,               // Clock
  input wire logic        presetn,            // Reset
  input wire logic        clk_en,             // Enable
  input wire logic        psel,               // APB
  input wire logic        penable,            // APB
  input wire logic        pready,             // APB
  input wire logic        pslverr,            // APB
  input wire logic        area0_width_sel_lo, // Pin
  input wire logic        area0_width_sel_hi, // Pin
  input wire logic        req_valid,          // Request
  input wire logic [31:0] req_addr,           // Address
  input wire logic        area0_select_n,     // Select
  input wire logic        area2_select_n,     // Select
  input wire logic        area3_select_n,     // Select
  input wire logic        area4_select_n,     // Select
  input wire logic        area5a_select_n,    // Select
  input wire logic        area5b_select_n,    // Select
  input wire logic        area6a_select_n,    // Select
  input wire logic        area6b_select_n,    // Select
  input wire logic        acc_valid,          // Valid
  input wire logic [1:0]  acc_width,          // Width
  input wire logic        acc_reserved,       // Area 7
  input wire logic        acc_onchip_io,      // On-chip
  input wire logic        strap_done          // Strap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sel_n;
  logic       req_ext;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  assign sel_n   = {area6b_select_n, area6a_select_n, area5b_select_n, area5a_select_n,
                    area4_select_n, area3_select_n, area2_select_n, area0_select_n};
  assign req_ext = clk_en && req_valid && req_addr[31:29] != 3'h7;

  // Enabled edges since reset, saturating
  always_comb begin
    cnt_d = cnt_q;
    if (clk_en && cnt_q != 4'hF) begin
      cnt_d = cnt_q + 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_AREA0_SEL: assert property (req_ext && req_addr[28:26] == 3'h0 |=> !area0_select_n)
    else $error("area 0 not selected");
  AST_AREA5B_SEL: assert property (req_ext && req_addr[28:25] == 4'hB |=>
    !area5b_select_n && acc_width inside {2'h1, 2'h2}) else $error("area 5B bad");
  AST_ONE_SEL: assert property (!(&sel_n) |-> $onehot(~sel_n) && acc_valid)
    else $error("select not single");
  AST_ACC_VALID: assert property (clk_en |=> acc_valid == $past(req_valid))
    else $error("valid not one cycle late");
  AST_RESERVED: assert property (req_ext && req_addr[28:26] == 3'h7 |=> acc_reserved && &sel_n)
    else $error("area 7 mishandled");
  AST_ONCHIP: assert property (clk_en && req_valid && req_addr[31:29] == 3'h7 |=>
    acc_onchip_io && &sel_n) else $error("on-chip segment mishandled");
  AST_AREA0_WIDTH: assert property (req_ext && strap_done && req_addr[28:26] == 3'h0 |=>
    acc_width == {$past(area0_width_sel_hi), $past(area0_width_sel_lo)})
    else $error("area 0 width not from pins");
  AST_STRAP_TIME: assert property (cnt_q == 4'h3 |-> strap_done)
    else $error("strap late");
  AST_STRAP_HOLD: assert property (strap_done |=> strap_done)
    else $error("strap done dropped");
  AST_APB_WAIT: assert property (clk_en && psel && !penable |-> ##2 pready)
    else $error("no ready in access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");

  COV_AREA0: cover property (!area0_select_n);
  COV_AREA5B: cover property (!area5b_select_n);
  COV_ONCHIP: cover property (acc_onchip_io);
  COV_ERR: cover property (pslverr);
endmodule // ead_checker

bind external_area_address_decoder ead_checker u_chk (
  .pclk, .presetn, .clk_en, .psel, .penable, .pready, .pslverr,
  .area0_width_sel_lo, .area0_width_sel_hi, .req_valid, .req_addr,
  .area0_select_n, .area2_select_n, .area3_select_n, .area4_select_n,
  .area5a_select_n, .area5b_select_n, .area6a_select_n, .area6b_select_n,
  .acc_valid, .acc_width, .acc_reserved, .acc_onchip_io, .strap_done
);

//--- dv/tb_top.sv
// Self-checking bench for the external area address decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk               = 1'b0;
  logic        presetn            = 1'b0;
  logic        clk_en             = 1'b1;
  logic        psel               = 1'b0;
  logic        penable            = 1'b0;
  logic        pwrite             = 1'b0;
  logic [11:0] paddr              = 12'h000;
  logic [31:0] pwdata             = 32'h0;
  logic        area0_width_sel_lo = 1'b1;
  logic        area0_width_sel_hi = 1'b1;
  logic        req_valid          = 1'b0;
  logic [31:0] req_addr           = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  sel_n;
  logic [1:0]  acc_width;
  logic [2:0]  acc_kind;
  logic        acc_internal_io;
  logic        acc_reserved;
  logic        acc_onchip_io;
  logic        strap_done;
  logic        strap_prohibited;
  logic [3:0]  hit_idx;
  logic        multi;
  int          bad_count          = 0;
  int          comparisons        = 0;
  logic [1:0]  exp_w [8];
  logic [2:0]  exp_k [8];
  logic [31:0] ofs [3]            = '{32'h0, 32'h02000000, 32'h03FFFFFC};

  external_area_address_decoder #(.ADDR_W(12)) dut (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .area0_width_sel_lo, .area0_width_sel_hi, .req_valid, .req_addr,
    .area0_select_n(sel_n[0]), .area2_select_n(sel_n[1]), .area3_select_n(sel_n[2]),
    .area4_select_n(sel_n[3]), .area5a_select_n(sel_n[4]), .area5b_select_n(sel_n[5]),
    .area6a_select_n(sel_n[6]), .area6b_select_n(sel_n[7]), .acc_valid(), .acc_width,
    .acc_kind, .acc_internal_io, .acc_reserved, .acc_onchip_io, .strap_done,
    .strap_prohibited
  );
  ead_mem_model mem (.sel_n, .hit_idx, .multi);

  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic err);
    int n;
    n = 0;
    @(posedge pclk);
    req_valid <= 1'b0;
    psel      <= 1'b1;
    pwrite    <= wr;
    paddr     <= a;
    pwdata    <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    if (!wr) chk(prdata, exp);
    chk(32'(pslverr), 32'(err));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, track the accepted value, read it back
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    if (!err) begin
      exp_w[a[4:2]] = d[1:0];
      exp_k[a[4:2]] = d[4:2];
    end
    apb(1'b1, a, d, 32'h0, err);
    apb(1'b0, a, 32'h0, {27'h0, exp_k[a[4:2]], exp_w[a[4:2]]}, 1'b0);
  endtask

  function automatic logic [12:0] exp_of(input logic [31:0] a);
    logic [2:0] c;
    logic [3:0] i;
    c = a[28:26];
    if (a[31:29] == 3'h7) return {4'h8, 9'h001};
    if (c == 3'h1) return {4'h8, 9'h004};
    if (c == 3'h7) return {4'h8, 9'h002};
    i = (c == 3'h0) ? 4'h0 : (c < 3'h5) ? 4'(c - 3'h1) : 4'(2 * c - 6 + a[25]);
    return {i, 1'b0, exp_w[i[2:0]], exp_k[i[2:0]], 3'h0};
  endfunction

  // One decode request, checked the cycle after it is taken
  task automatic acc(input logic [31:0] a);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_addr  <= a;
    @(posedge pclk);
    #1;
    chk(32'({hit_idx, multi, acc_width, acc_kind, acc_internal_io, acc_reserved,
             acc_onchip_io}), 32'(exp_of(a)));
  endtask

  task automatic sweep();
    for (int n = 0; n < 7; n++) begin
      for (int c = 0; c < 8; c++) begin
        for (int h = 0; h < 3; h++) begin
          acc(32'(n) * 32'h20000000 + 32'(c) * 32'h04000000 + ofs[h]);
        end
      end
    end
  endtask

  task automatic do_reset(input logic [1:0] pins);
    int n;
    n = 0;
    @(posedge pclk);
    presetn            <= 1'b0;
    req_valid          <= 1'b0;
    area0_width_sel_hi <= pins[1];
    area0_width_sel_lo <= pins[0];
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      exp_w[i] = ead_pkg::RST_WIDTH;
      exp_k[i] = ead_pkg::RST_KIND;
    end
    exp_w[0] = pins;
    while (strap_done !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (strap_done !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  initial begin
    // ------------------------------------------------------------
    // Area 0 width strap across resets
    // ------------------------------------------------------------
    for (int p = 0; p < 4; p++) begin
      do_reset(2'(p));
      chk(32'(strap_prohibited), 32'(p == 0));
      apb(1'b0, 12'h020, 32'h0, {28'h0, p == 0, 1'b1, 2'(p)}, 1'b0);
      acc(32'h00000040);
      acc(32'hC0000040);
    end
    $display("test strap done");
    // ------------------------------------------------------------
    // Reset values, refusals, default decode
    // ------------------------------------------------------------
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, {27'h0, exp_k[i], exp_w[i]}, 1'b0);
    end
    apb(1'b0, 12'h024, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h020, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h020, 32'h0, 32'h00000007, 1'b0);
    sweep();
    for (int c = 0; c < 7; c++) begin
      if (c != 1) acc(32'hE0000000 + 32'(c) * 32'h04000000);
    end
    acc(32'h08000000);
    @(posedge pclk);
    clk_en   <= 1'b0;
    req_addr <= 32'h14000000;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(sel_n), 32'hFD);
    @(posedge pclk);
    clk_en <= 1'b1;
    $display("test default decode done");
    // ------------------------------------------------------------
    // Programmed widths and kinds
    // ------------------------------------------------------------
    wr(12'h004, 32'h0000000B, 1'b0);
    wr(12'h008, 32'h0000000A, 1'b0);
    wr(12'h00C, 32'h0000000D, 1'b0);
    wr(12'h010, 32'h00000003, 1'b0);
    wr(12'h014, 32'h00000012, 1'b0);
    wr(12'h018, 32'h00000001, 1'b0);
    wr(12'h01C, 32'h00000006, 1'b1);
    wr(12'h004, 32'h00000000, 1'b1);
    wr(12'h014, 32'h00000003, 1'b1);
    wr(12'h018, 32'h00000003, 1'b1);
    wr(12'h01C, 32'h00000003, 1'b1);
    wr(12'h008, 32'h00000009, 1'b1);
    wr(12'h00C, 32'h0000000A, 1'b1);
    wr(12'h014, 32'h00000011, 1'b1);
    sweep();
    $display("test programmed decode done");
    report_and_stop();
  end
endmodule // tb_top
